// File: include/panel_defines.svh
// Constants of the front-panel maintenance sequencer: register map,
// field positions, reset values and timing counts.
// Assumes a 250 MHz core clock; included by bare name.
`ifndef PANEL_DEFINES_SVH
`define PANEL_DEFINES_SVH

// Register byte addresses
`define REG_CTRL        8'h00
`define REG_STATUS      8'h04
`define REG_LOG_SEL     8'h08
`define REG_LOG_CODE    8'h0c
`define REG_LOG_TIME    8'h10

// CTRL fields and reset value
`define CTRL_SERVO_ON   0
`define CTRL_WPROT      1
`define CTRL_RESET      2'h0

// STATUS field positions
`define ST_STATE_LSB    0
`define ST_FUNC_LSB     4
`define ST_VALUE_LSB    8
`define ST_DEF_PEND     12
`define ST_LOG_CNT_LSB  16

// Confirm step shown when a function is armed
`define CONFIRM_VALUE   2'h2
`define LOG_DEPTH       10

// Times and clock rate
`define CLK_KHZ         250000
`define LONG_PRESS_MS   1000
`define FLASH_MS        1000
`define STAMP_TICK_MS   100
`define DEBOUNCE_MS     10
`define LONG_PRESS_CYC  (`LONG_PRESS_MS * `CLK_KHZ)
`define FLASH_CYC       (`FLASH_MS * `CLK_KHZ)
`define STAMP_TICK_CYC  (`STAMP_TICK_MS * `CLK_KHZ)
`define DEBOUNCE_CYC    (`DEBOUNCE_MS * `CLK_KHZ)

// Bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// File: include/panel_pkg.sv
// Types of the front-panel maintenance sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package panel_pkg;

    // Sequencer states
    typedef enum logic [2:0] {
        S_LIST      = 3'h0,
        S_FUNC      = 3'h1,
        S_DONE      = 3'h2,
        S_REJECT    = 3'h3,
        S_PENDING   = 3'h4,
        S_REBOOT    = 3'h5,
        S_SERVO_OFF = 3'h6
    } seq_state_t;

    // Functions in the list, in scroll order
    typedef enum logic [2:0] {
        history_view_function     = 3'h0,
        alarm_log_clear_function  = 3'h1,
        soft_reboot_function      = 3'h2,
        factory_defaults_function = 3'h3,
        write_protect_function    = 3'h4
    } func_sel_t;

    // What the display shows
    typedef enum logic [2:0] {
        D_FUNC_LIST  = 3'h0,
        D_VALUE      = 3'h1,
        D_DONE_FLASH = 3'h2,
        D_REJECT     = 3'h3,
        D_PENDING    = 3'h4,
        D_SERVO_OFF  = 3'h5
    } disp_kind_t;

endpackage : panel_pkg

// File: verilog/cycle_timer.sv
// Counts clock cycles while run is high and pulses once every N cycles.
// Assumes run comes from logic on the same clock.
`timescale 1ns/10ps
module cycle_timer #(
    parameter int N = 4,
    parameter int W = 28
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic ce,
    // Control and result
    input  wire logic run,
    output logic      hit
);
    logic [W-1:0] cnt_r;

    generate
        if (N < 2 || N >= (64'h1 << W)) begin : g_bad_n
            $error("cycle_timer: N does not fit W");
        end
    endgenerate

    // Counter restarts whenever run drops
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
            hit   <= 1'b0;
        end else if (ce) begin
            if (!run) begin
                cnt_r <= '0;
                hit   <= 1'b0;
            end else if (cnt_r == W'(N - 1)) begin
                cnt_r <= '0;
                hit   <= 1'b1;
            end else begin
                cnt_r <= cnt_r + 1'b1;
                hit   <= 1'b0;
            end
        end
    end

endmodule : cycle_timer

// File: verilog/key_debounce.sv
// Synchronises and debounces one panel key.
// Assumes the key pin is asynchronous and high while pressed.
`timescale 1ns/10ps
module key_debounce #(
    parameter int STABLE_CYC = 16,
    parameter int W          = 22
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic ce,
    // Key pin and clean outputs
    input  wire logic key_pin,
    output logic      held,
    output logic      press
);
    logic         s1_r;
    logic         s2_r;
    logic [W-1:0] cnt_r;

    generate
        if (STABLE_CYC < 2 || STABLE_CYC >= (64'h1 << W)) begin : g_bad_cyc
            $error("key_debounce: STABLE_CYC does not fit W");
        end
    endgenerate

    // Two-stage synchroniser
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end else if (ce) begin
            s1_r <= key_pin;
            s2_r <= s1_r;
        end
    end

    // Level accepted only after it stays stable
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
            held  <= 1'b0;
            press <= 1'b0;
        end else if (ce) begin
            press <= 1'b0;
            if (s2_r == held) begin
                cnt_r <= '0;
            end else if (cnt_r == W'(STABLE_CYC - 1)) begin
                cnt_r <= '0;
                held  <= s2_r;
                press <= s2_r;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

endmodule : key_debounce

// File: verilog/panel_aux_function_sequencer.sv
// Front-panel sequencer of three maintenance functions,
// alarm history store and AXI4-Lite slave.
// Assumes async key pins; alarms and reboot_done on clk;
// nrst marks control power-on.
//
// Added by the designer: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`include "panel_defines.svh"

// What this block does
// [R01] Alarm reset, mains loss keep history
// [R02] Only log clear erases history
// [R03] Long data press enters, unarmed
// [R04] Up arms log clear
// [R05] Armed mode clears history, flashes done; an alarm in the commit cycle blocks the clear
// [R06] Unarmed mode in clear rejects
// [R07] Clear done returns to confirm
// [R08] Long data press returns to list
// [R09] Operator checks write protect first
// [R10] Up arms reboot
// [R11] Armed mode enters reboot pending
// [R12] Unarmed mode in reboot rejects
// [R13] Mode in pending reboots, then servo-off
// [R14] Reboot applies power-cycle parameters
// [R15] Defaults refused while servo on
// [R16] Up arms defaults
// [R17] Armed mode restores defaults
// [R18] Defaults done flashes one second
// [R19] Unarmed mode in defaults rejects
// [R20] Defaults done returns to confirm
// [R21] Defaults apply after next power-on
// [R22] Ten alarms, 100 ms stamps
// [R23] Debounced keys, one-second long press
// [R24] Entry resets value unarmed
module panel_aux_function_sequencer #(
    parameter int LONG_PRESS_CYC = `LONG_PRESS_CYC,
    parameter int FLASH_CYC      = `FLASH_CYC,
    parameter int STAMP_TICK_CYC = `STAMP_TICK_CYC,
    parameter int DEBOUNCE_CYC   = `DEBOUNCE_CYC
) (
    // Clock, reset, enable
    input  wire logic             clk,
    input  wire logic             nrst,
    input  wire logic             ce,
    // Panel key pins, high while pressed
    input  wire logic             key_mode,
    input  wire logic             key_up,
    input  wire logic             key_down,
    input  wire logic             key_data,
    // Panel display
    output panel_pkg::disp_kind_t disp_kind,
    output logic [7:0]            disp_func,
    output logic [1:0]            disp_value,
    // Alarm events from the drive
    input  wire logic             alarm_valid,
    input  wire logic [7:0]       alarm_code,
    // Actions toward storage and reboot machinery
    output logic                  defaults_req,
    output logic                  defaults_pending,
    output logic                  reboot_req,
    input  wire logic             reboot_done,
    // AXI4-Lite slave
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready
);
    import panel_pkg::*;

    seq_state_t  state_r;
    func_sel_t   func_r;
    logic [1:0]  value_r;
    logic [1:0]  ctrl_r;
    logic [3:0]  log_sel_r;
    logic [3:0]  log_cnt_r;
    logic [7:0]  log_code_r [`LOG_DEPTH];
    logic [31:0] log_time_r [`LOG_DEPTH];
    logic [31:0] stamp_r;
    logic        lp_fired_r;
    logic        up_p;
    logic        dn_p;
    logic        mode_p;
    logic        data_held;
    logic        lp_hit;
    logic        flash_hit;
    logic        tick_hit;
    logic        lp;
    logic        commit;
    logic        armed;
    logic        clr_go;
    logic        def_go;
    logic        rst_go;
    logic        wr_go;
    logic        servo_on;
    logic        wprot;

    // Debounced keys
    key_debounce #(.STABLE_CYC(DEBOUNCE_CYC), .W(22)) u_deb_mode (
        .clk, .nrst, .ce, .key_pin(key_mode),
        .held(), .press(mode_p)
    ); // R23
    key_debounce #(.STABLE_CYC(DEBOUNCE_CYC), .W(22)) u_deb_up (
        .clk, .nrst, .ce, .key_pin(key_up),
        .held(), .press(up_p)
    );
    key_debounce #(.STABLE_CYC(DEBOUNCE_CYC), .W(22)) u_deb_dn (
        .clk, .nrst, .ce, .key_pin(key_down),
        .held(), .press(dn_p)
    );
    key_debounce #(.STABLE_CYC(DEBOUNCE_CYC), .W(22)) u_deb_data (
        .clk, .nrst, .ce, .key_pin(key_data),
        .held(data_held), .press()
    );

    // Long-press timer while data held
    cycle_timer #(.N(LONG_PRESS_CYC), .W(28)) u_lp_timer (
        .clk, .nrst, .ce,
        .run(data_held & ~lp_fired_r), .hit(lp_hit)
    ); // R23

    // Done and reject flash period
    cycle_timer #(.N(FLASH_CYC), .W(28)) u_flash_timer (
        .clk, .nrst, .ce,
        .run((state_r == S_DONE) || (state_r == S_REJECT)), .hit(flash_hit)
    );

    // Timestamp tick since control power-on
    cycle_timer #(.N(STAMP_TICK_CYC), .W(28)) u_stamp_timer (
        .clk, .nrst, .ce, .run(1'b1), .hit(tick_hit)
    );

    // Decoded key events and commit decisions
    assign lp       = lp_hit;
    assign servo_on = ctrl_r[`CTRL_SERVO_ON];
    assign wprot    = ctrl_r[`CTRL_WPROT];
    assign armed    = (value_r == `CONFIRM_VALUE);
    assign commit   = (state_r == S_FUNC) && !lp && mode_p;
    assign clr_go   = commit && (func_r == alarm_log_clear_function)
                      && armed && !wprot;                          // R05
    assign rst_go   = commit && (func_r == soft_reboot_function) && armed;
    assign def_go   = commit && (func_r == factory_defaults_function)
                      && armed && !servo_on;                       // R15

    // One long press per hold
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lp_fired_r <= 1'b0;
        end else if (ce) begin
            if (!data_held) begin
                lp_fired_r <= 1'b0;
            end else if (lp_hit) begin
                lp_fired_r <= 1'b1;
            end
        end
    end

    // Sequencer state machine
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= S_LIST;
            func_r  <= history_view_function;
            value_r <= 2'h0;
        end else if (ce) begin
            unique case (state_r)
                S_LIST: begin
                    if (lp && (func_r == alarm_log_clear_function ||
                               func_r == soft_reboot_function ||
                               func_r == factory_defaults_function)) begin
                        state_r <= S_FUNC; // R03
                        value_r <= 2'h0;   // R24
                    end else if (up_p && func_r != write_protect_function) begin
                        func_r <= func_sel_t'(func_r + 3'h1);
                    end else if (dn_p && func_r != history_view_function) begin
                        func_r <= func_sel_t'(func_r - 3'h1);
                    end
                end
                S_FUNC: begin
                    if (lp) begin
                        state_r <= S_LIST; // R08
                    end else if (mode_p) begin
                        if (clr_go || def_go) begin
                            state_r <= S_DONE;    // R05 R17
                        end else if (rst_go) begin
                            state_r <= S_PENDING; // R11
                        end else begin
                            state_r <= S_REJECT;  // R06 R12 R19
                        end
                    end else if (up_p && !armed) begin
                        value_r <= value_r + 2'h1; // R04 R10 R16
                    end else if (dn_p && value_r != 2'h0) begin
                        value_r <= value_r - 2'h1;
                    end
                end
                S_DONE: begin
                    if (flash_hit) begin
                        state_r <= S_FUNC; // R07 R18 R20
                    end
                end
                S_REJECT: begin
                    if (flash_hit) begin
                        state_r <= S_FUNC;
                    end
                end
                S_PENDING: begin
                    if (mode_p) begin
                        state_r <= S_REBOOT; // R13
                    end
                end
                S_REBOOT: begin
                    if (reboot_done) begin
                        state_r <= S_SERVO_OFF; // R13
                    end
                end
                S_SERVO_OFF: begin
                    if (mode_p) begin
                        state_r <= S_LIST;
                        func_r  <= history_view_function;
                    end
                end
                default: begin
                    state_r <= S_LIST;
                end
            endcase
        end
    end

    // Action pulses; defaults wait for power-on
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            defaults_req     <= 1'b0;
            defaults_pending <= 1'b0;
            reboot_req       <= 1'b0;
        end else if (ce) begin
            defaults_req <= def_go; // R17
            reboot_req   <= (state_r == S_PENDING) && mode_p; // R13 R14
            if (def_go) begin
                defaults_pending <= 1'b1; // R21
            end
        end
    end

    // Display drive
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            disp_kind  <= D_FUNC_LIST;
            disp_func  <= 8'h00;
            disp_value <= 2'h0;
        end else if (ce) begin
            disp_value <= value_r;
            unique case (func_r)
                write_protect_function: disp_func <= 8'h10;
                default:                disp_func <= {5'h00, func_r};
            endcase
            unique case (state_r)
                S_LIST:      disp_kind <= D_FUNC_LIST;
                S_FUNC:      disp_kind <= D_VALUE;
                S_DONE:      disp_kind <= D_DONE_FLASH;
                S_REJECT:    disp_kind <= D_REJECT;
                S_PENDING:   disp_kind <= D_PENDING;
                S_REBOOT:    disp_kind <= D_PENDING;
                S_SERVO_OFF: disp_kind <= D_SERVO_OFF;
                default:     disp_kind <= D_FUNC_LIST;
            endcase
        end
    end

    // Timestamp in 100 ms units
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            stamp_r <= 32'h0;
        end else if (ce && tick_hit) begin
            stamp_r <= stamp_r + 32'h1; // R22
        end
    end

    // Entry count; the log-clear commit empties it unless an alarm arrives in that cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            log_cnt_r <= 4'h0;
        end else if (ce) begin
            if (alarm_valid) begin
                if (log_cnt_r != 4'(`LOG_DEPTH)) begin
                    log_cnt_r <= log_cnt_r + 4'h1; // R22
                end
            end else if (clr_go) begin
                log_cnt_r <= 4'h0; // R02 R01
            end
        end
    end

    // History storage, newest at entry 0
    always_ff @(posedge clk) begin
        if (ce && alarm_valid) begin
            log_code_r[0] <= alarm_code;
            log_time_r[0] <= stamp_r;
            for (int i = 1; i < `LOG_DEPTH; i++) begin
                log_code_r[i] <= log_code_r[i-1]; // R22
                log_time_r[i] <= log_time_r[i-1];
            end
        end
    end

    // Bus write: address and data taken together
    assign wr_go         = ce && s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = ce && !s_axi_rvalid;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r       <= `CTRL_RESET;
            log_sel_r    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (ce) begin
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= `RESP_OKAY;
                unique case (s_axi_awaddr)
                    `REG_CTRL: begin
                        if (s_axi_wstrb[0]) ctrl_r <= s_axi_wdata[1:0];
                    end
                    `REG_LOG_SEL: begin
                        if (s_axi_wstrb[0]) log_sel_r <= s_axi_wdata[3:0];
                    end
                    `REG_STATUS, `REG_LOG_CODE, `REG_LOG_TIME: begin
                    end
                    default: s_axi_bresp <= `RESP_SLVERR;
                endcase
            end
        end
    end

    // Bus read
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (ce) begin
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end else if (s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RESP_OKAY;
                s_axi_rdata  <= 32'h0;
                unique case (s_axi_araddr)
                    `REG_CTRL:    s_axi_rdata <= {30'h0, ctrl_r};
                    `REG_STATUS: begin
                        s_axi_rdata[`ST_STATE_LSB +: 3]   <= state_r;
                        s_axi_rdata[`ST_FUNC_LSB +: 3]    <= func_r;
                        s_axi_rdata[`ST_VALUE_LSB +: 2]   <= value_r;
                        s_axi_rdata[`ST_DEF_PEND]         <= defaults_pending;
                        s_axi_rdata[`ST_LOG_CNT_LSB +: 4] <= log_cnt_r;
                    end
                    `REG_LOG_SEL: s_axi_rdata <= {28'h0, log_sel_r};
                    `REG_LOG_CODE: begin
                        if (log_sel_r < log_cnt_r)
                            s_axi_rdata <= {24'h0, log_code_r[log_sel_r]};
                    end
                    `REG_LOG_TIME: begin
                        if (log_sel_r < log_cnt_r)
                            s_axi_rdata <= log_time_r[log_sel_r];
                    end
                    default: s_axi_rresp <= `RESP_SLVERR;
                endcase
            end
        end
    end

endmodule : panel_aux_function_sequencer

// File: bench/panel_checks_properties.sv
// Checker of display, action and write relations.
// Assumes it is bound to the sequencer and sees its ports only.
`timescale 1ns/10ps
module panel_checks #(
    parameter int FLASH_CYC = 8
) (
    // Clock and reset
    input wire logic       clk,
    input wire logic       nrst,
    // Display and actions
    input wire logic [2:0] disp_kind,
    input wire logic [1:0] disp_value,
    input wire logic       defaults_req,
    input wire logic       defaults_pending,
    input wire logic       reboot_req,
    // Write channels
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_bvalid
);
    import panel_pkg::*;
    int flash_cnt_r;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Cycles in the current flash
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst)
            flash_cnt_r <= 0;
        else if (disp_kind inside {D_DONE_FLASH, D_REJECT})
            flash_cnt_r <= flash_cnt_r + 1;
        else
            flash_cnt_r <= 0;
    end
    a_defaults_pulse: assert property (defaults_req |=> !defaults_req)
        else $error("defaults request too long");
    a_defaults_kept: assert property (defaults_req || defaults_pending |=> defaults_pending)
        else $error("defaults pending lost");
    a_defaults_armed: assert property (defaults_req |-> $past(disp_value) == 2'h2)
        else $error("defaults without confirm");
    a_reboot_pending: assert property (reboot_req |-> $past(disp_kind) == D_PENDING)
        else $error("reboot not from pending");
    a_done_length: assert property ($fell(disp_kind == D_DONE_FLASH) |->
        flash_cnt_r == FLASH_CYC + 1 && disp_kind == D_VALUE && disp_value == 2'h2)
        else $error("done flash wrong");
    a_reject_length: assert property ($fell(disp_kind == D_REJECT) |->
        flash_cnt_r == FLASH_CYC + 1 && disp_kind == D_VALUE)
        else $error("reject flash wrong");
    a_enter_unarmed: assert property (disp_kind == D_VALUE &&
        $past(disp_kind) == D_FUNC_LIST |-> disp_value == 2'h0)
        else $error("entry not unarmed");
    a_write_taken: assert property (s_axi_awready |-> !s_axi_bvalid && s_axi_wvalid ##1 s_axi_bvalid)
        else $error("write answer wrong");
endmodule : panel_checks

// File: bench/panel_operator.sv
// Operator model: one key at a time.
// Assumes key pins are low while released.
`timescale 1ns/10ps
module panel_operator (
    // Clock
    input wire logic clk,
    // Key pins, high while pressed
    output logic     key_mode,
    output logic     key_up,
    output logic     key_down,
    output logic     key_data
);
    logic [3:0] pins = 4'h0;
    // Index 3 mode, 2 up, 1 down, 0 data
    assign {key_mode, key_up, key_down, key_data} = pins;
    // Rest, then hold; forty cycles stands for a long press
    task automatic press(input int k, input int hold);
        repeat (10) @(posedge clk);
        pins[k] <= 1'b1;
        repeat (hold) @(posedge clk);
        pins[k] <= 1'b0;
    endtask : press
endmodule : panel_operator

// File: bench/panel_aux_function_sequencer_test.sv
// Panel sequencer bench: operator model keys, AXI4-Lite registers.
// Assumes shortened counts.
`timescale 1ns/10ps
`include "panel_defines.svh"
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin miscompares++; \
    $display("BAD %s expected %0h seen %0h", n, e, s); end end
module panel_aux_function_sequencer_test;
    import panel_pkg::*;
    logic        clk = 0, nrst = 0, ce = 1, alarm_valid = 0, reboot_done = 0;
    logic        key_mode, key_up, key_down, key_data, defaults_req, defaults_pending;
    logic        reboot_req, aw_v = 0, w_v = 0, b_r = 1, ar_v = 0, r_r = 1;
    logic        aw_rdy, w_rdy, b_v, ar_rdy, r_v;
    logic [7:0]  alarm_code = 8'h00, disp_func, aw_a = 8'h00, ar_a = 8'h00;
    logic [1:0]  disp_value, b_resp, r_resp, resp;
    logic [31:0] w_d = 32'h0, r_d, rdat;
    disp_kind_t  disp_kind;
    int          miscompares = 0, checked = 0, reboots = 0;
    always #2 clk = ~clk;
    always @(posedge clk) if (reboot_req === 1'b1) reboots <= reboots + 1;
    panel_aux_function_sequencer #(.LONG_PRESS_CYC(20), .FLASH_CYC(8), .STAMP_TICK_CYC(4),
        .DEBOUNCE_CYC(3)) u_dut (.clk(clk), .nrst(nrst), .ce(ce), .key_mode(key_mode),
        .key_up(key_up), .key_down(key_down), .key_data(key_data), .disp_kind(disp_kind),
        .disp_func(disp_func), .disp_value(disp_value), .alarm_valid(alarm_valid),
        .alarm_code(alarm_code), .defaults_req(defaults_req), .reboot_req(reboot_req),
        .defaults_pending(defaults_pending), .reboot_done(reboot_done), .s_axi_awaddr(aw_a),
        .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_v),
        .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
        .s_axi_rdata(r_d), .s_axi_rresp(r_resp), .s_axi_rvalid(r_v), .s_axi_rready(r_r));
    panel_operator u_op (.clk(clk), .key_mode(key_mode), .key_up(key_up),
        .key_down(key_down), .key_data(key_data));
    // Register write; bready stays high, bvalid marks the take
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        {aw_a, w_d, aw_v, w_v} <= {a, d, 2'b11};
        do @(posedge clk); while (!b_v);
        {aw_v, w_v} <= 2'b00;
        @(posedge clk);
    endtask : wr
    // Register read; rready stays high
    task automatic rd(input logic [7:0] a);
        {ar_a, ar_v} <= {a, 1'b1};
        do @(posedge clk); while (!r_v);
        ar_v <= 1'b0;
        rdat = r_d;
        resp = r_resp;
        @(posedge clk);
    endtask : rd
    // Wait a bounded span for a display kind
    task automatic see(input disp_kind_t k);
        for (int n = 0; n < 80 && disp_kind !== k; n++) @(posedge clk);
        `CHK("disp_kind", k, disp_kind)
    endtask : see
    // Scroll to the top of the list, then down to function f
    task automatic go_enter(input int f);
        repeat (4) u_op.press(1, 10);
        repeat (f) u_op.press(2, 10);
        u_op.press(0, 40);
        see(D_VALUE);
    endtask : go_enter
    task automatic tally_and_finish;
        if (miscompares == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        rd(`REG_CTRL);
        `CHK("ctrl", 32'h0, rdat)
        for (int i = 0; i < 3; i++) begin
            alarm_valid <= 1'b1;
            alarm_code  <= 8'h21 + 8'(i);
            @(posedge clk);
        end
        alarm_valid <= 1'b0;
        wr(`REG_LOG_SEL, 32'h0);
        rd(`REG_LOG_CODE);
        `CHK("newest code", 32'h23, rdat)
        rd(8'h40);
        `CHK("unmapped", `RESP_SLVERR, resp)
        // Log clear: refused unarmed, then armed and committed
        go_enter(1);
        `CHK("entry value", 2'h0, disp_value)
        u_op.press(3, 10);
        see(D_REJECT);
        see(D_VALUE);
        rd(`REG_STATUS);
        `CHK("count kept", 4'h3, rdat[19:16])
        repeat (3) u_op.press(2, 10);
        `CHK("clear armed", 2'h2, disp_value)
        wr(`REG_CTRL, 32'h2);
        u_op.press(3, 10);
        see(D_REJECT);
        see(D_VALUE);
        wr(`REG_CTRL, 32'h0);
        u_op.press(3, 10);
        see(D_DONE_FLASH);
        rd(`REG_STATUS);
        `CHK("count cleared", 4'h0, rdat[19:16])
        see(D_VALUE);
        u_op.press(0, 40);
        see(D_FUNC_LIST);
        `CHK("list func", 8'h01, disp_func)
        // Reboot: refused unarmed, then pending, reboot, servo-off
        go_enter(2);
        u_op.press(3, 10);
        see(D_REJECT);
        see(D_VALUE);
        repeat (2) u_op.press(2, 10);
        u_op.press(3, 10);
        see(D_PENDING);
        `CHK("no reboot yet", 0, reboots)
        u_op.press(3, 10);
        reboot_done <= 1'b1;
        see(D_SERVO_OFF);
        reboot_done <= 1'b0;
        `CHK("reboots", 1, reboots)
        u_op.press(3, 10);
        see(D_FUNC_LIST);
        // Defaults: refused unarmed, refused with servo on, then done
        wr(`REG_CTRL, 32'h1);
        go_enter(3);
        u_op.press(3, 10);
        see(D_REJECT);
        see(D_VALUE);
        repeat (2) u_op.press(2, 10);
        u_op.press(3, 10);
        see(D_REJECT);
        see(D_VALUE);
        `CHK("refused", 1'b0, defaults_pending)
        wr(`REG_CTRL, 32'h0);
        u_op.press(3, 10);
        see(D_DONE_FLASH);
        `CHK("pending", 1'b1, defaults_pending)
        see(D_VALUE);
        `CHK("confirm kept", 2'h2, disp_value)
        tally_and_finish();
    end
    // Watchdog against a hang
    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        tally_and_finish();
    end
endmodule : panel_aux_function_sequencer_test
bind panel_aux_function_sequencer panel_checks #(.FLASH_CYC(FLASH_CYC)) u_checks (
    .clk, .nrst, .disp_kind, .disp_value, .defaults_req, .defaults_pending,
    .reboot_req, .s_axi_wvalid, .s_axi_awready, .s_axi_bvalid);
